// *** core/fnsc_pkg.sv ***
// Shared constants, register map and types of the synthesizer control block
package fnsc_pkg;
  // Calibration timing, counted in phase detector clock ticks
  localparam int CAL_PD_CYCLES = 1500;
  localparam int BAND_COUNT    = 128;
  localparam int STEP_TICKS    = CAL_PD_CYCLES / BAND_COUNT;
  localparam logic [6:0] BAND_MIN = 7'h00;
  localparam logic [6:0] BAND_MAX = 7'h7F;
  localparam int FRAC_W        = 24;

  // Register byte addresses
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_BAND   = 12'h004;
  localparam logic [11:0] ADDR_B1_INT = 12'h008;
  localparam logic [11:0] ADDR_B1_FHI = 12'h00C;
  localparam logic [11:0] ADDR_B1_FLO = 12'h010;
  localparam logic [11:0] ADDR_B2_INT = 12'h014;
  localparam logic [11:0] ADDR_B2_FHI = 12'h018;
  localparam logic [11:0] ADDR_B2_FLO = 12'h01C;
  localparam logic [11:0] ADDR_REFDIV = 12'h020;
  localparam logic [11:0] ADDR_PUMP   = 12'h024;
  localparam logic [11:0] ADDR_FILT   = 12'h028;
  localparam logic [11:0] ADDR_STATUS = 12'h02C;

  // Field positions
  localparam int CTRL_VCO_LSB  = 0;
  localparam int CTRL_LODIV    = 2;
  localparam int CTRL_CALEN    = 3;
  localparam int CTRL_CTV_LSB  = 4;
  localparam int CTRL_VCOI_LSB = 9;
  localparam int REF_BYP       = 0;
  localparam int REF_VAL_LSB   = 13;
  localparam int PUMP_LOW      = 5;
  localparam int PUMP_AUTO     = 6;
  localparam int PUMP_LF_LSB   = 8;
  localparam int FILT_ACT      = 0;
  localparam int FILT_POL      = 1;
  localparam int FILT_LOI_LSB  = 2;
  localparam int STAT_FAIL     = 7;
  localparam int STAT_BUSY     = 8;
  localparam int STAT_DONE     = 9;
  localparam int STAT_LOOP     = 10;
  localparam int STAT_BANK     = 11;

  // Reset values
  localparam logic [1:0]  RST_VCO   = 2'h0;
  localparam logic        RST_CALEN = 1'b1;
  localparam logic [4:0]  RST_CTV   = 5'h10;
  localparam logic [3:0]  RST_VCOI  = 4'h0;
  localparam logic [6:0]  RST_BAND  = 7'h40;
  localparam logic [9:0]  RST_INT   = 10'h040;
  localparam logic [2:0]  RST_REFV  = 3'h2;
  localparam logic [4:0]  RST_PUMP  = 5'h1F;
  localparam logic [1:0]  RST_LF    = 2'h1;
  localparam logic [3:0]  RST_LOI   = 4'h0;
  localparam logic [2:0]  REF_MIN   = 3'h2;

  // Pump current at full code
  localparam int PUMP_FULL_UA = 120;
  localparam int PUMP_LOW_UA  = 30;
  localparam int PUMP_CODE_MAX = 31;

  typedef enum logic [1:0] {
    CAL_IDLE   = 2'b00,
    CAL_SEARCH = 2'b01,
    CAL_LOCK   = 2'b11
  } fnsc_cal_t;
endpackage

// *** core/fnsc_frac_seq.sv ***
// Fractional sequence generator selecting the prescaler modulus per cycle
`timescale 1ns/1ns
module fnsc_frac_seq #(
  parameter int W = 24
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  // Feedback cycle and fraction
  input  wire logic         step_i,
  input  wire logic [W-1:0] frac_i,
  // Divide by N+1 for the next cycle
  output logic              carry_o
);
  logic [W-1:0] acc_q;
  logic [W:0]   sum;

  assign sum = {1'b0, acc_q} + {1'b0, frac_i};

  // Accumulator overflow averages the ratio to N + frac / 2^W
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc_q   <= '0;
      carry_o <= 1'b0;
    end else if (step_i) begin
      acc_q   <= sum[W-1:0];
      carry_o <= sum[W];
    end
  end

  property p_carry_wrap;
    @(posedge clk_i) disable iff (!rst_n_i)
      step_i |=> (carry_o == ($past(acc_q) > acc_q || (frac_i == '0 && 1'b0)));
  endproperty
  a_carry_wrap: assert property (p_carry_wrap) else $error("carry not tied to wrap");
endmodule

// *** core/fnsc_synth_ctrl.sv ***
// Control logic of the fractional-N synthesizer with APB register access
`timescale 1ns/1ns
// What this block does
// - Select one of three oscillators and divide its output by 2 or 4
// - Each oscillator has 128 bands; band chosen automatically or taken from the band register
// - Start band selection on each enable pin rise, then close the loop
// - Search adds capacitance steps one by one until frequency is near target
// - Report chosen band; 0 or 127 means failure, 1 to 126 success
// - Band selection takes about 1500 phase detector clock cycles
// - Bypass low uses reference divider; bypass high divides by one
// - Three-bit value at bits 15 to 13 sets ratio 2 to 7
// - Two frequency banks; mode pin high selects the second bank
// - Loop drives oscillator to feedback ratio times reference over ratio
// - Ten-bit integer part plus fraction times 2^24 split high 16, low 8
// - Dual-modulus prescaler with fractional sequence gives fine steps
// - Code 31 gives 120 uA; low current bit cuts it to 30 uA
// - Automatic bandwidth correction sets pump code from gain; off after reset
// - Filter enable drives amplifier on; low disables it, pin high impedance
module fnsc_synth_ctrl #(
  parameter int STEP_TICKS = fnsc_pkg::STEP_TICKS
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Pins and analog status
  input  wire logic        chip_enable_pin_i,
  input  wire logic        mode_pin_i,
  input  wire logic        vco_above_i,
  // Loop timing and measurement, same clock
  input  wire logic        pd_tick_i,
  input  wire logic        fb_tick_i,
  input  wire logic [4:0]  vco_gain_code_i,
  // Oscillator controls
  output logic      [1:0]  vco_select_o,
  output logic             lo_div4_o,
  output logic      [6:0]  vco_band_o,
  output logic      [4:0]  coarse_tune_voltage_o,
  output logic      [3:0]  vco_core_current_o,
  output logic      [3:0]  lo_buffer_current_o,
  output logic             loop_closed_o,
  // Dividers
  output logic      [2:0]  ref_div_ratio_o,
  output logic      [10:0] fb_div_ratio_o,
  // Charge pump and filter
  output logic      [4:0]  pump_code_o,
  output logic      [7:0]  pump_ua_o,
  output logic      [1:0]  loop_factor_select_o,
  output logic             filter_amp_en_o,
  output logic             filter_pin_hiz_o,
  output logic             detector_polarity_o
);
  // Registers
  logic [1:0]  vco_sel_q;
  logic        lo_div_q;
  logic        cal_en_q;
  logic [4:0]  ctv_q;
  logic [3:0]  vcoi_q;
  logic [6:0]  band_def_q;
  logic [9:0]  int1_q;
  logic [9:0]  int2_q;
  logic [23:0] frac1_q;
  logic [23:0] frac2_q;
  logic        ref_byp_q;
  logic [2:0]  ref_val_q;
  logic [4:0]  pump_q;
  logic        pump_low_q;
  logic        auto_bw_q;
  logic [1:0]  lf_q;
  logic        filt_act_q;
  logic        pol_q;
  logic [3:0]  loi_q;
  logic        done_q;
  // Calibration state
  localparam fnsc_pkg::fnsc_cal_t CAL_IDLE   = fnsc_pkg::CAL_IDLE;
  localparam fnsc_pkg::fnsc_cal_t CAL_SEARCH = fnsc_pkg::CAL_SEARCH;
  localparam fnsc_pkg::fnsc_cal_t CAL_LOCK   = fnsc_pkg::CAL_LOCK;
  fnsc_pkg::fnsc_cal_t state_q;
  logic [6:0]  result_q;
  logic [6:0]  band_q;
  logic [7:0]  tick_q;
  logic        cal_done_ev;
  // Pin synchronisers
  logic [2:0]  en_sync_q;
  logic [2:0]  mode_sync_q;
  logic [2:0]  above_sync_q;
  logic        en_q;
  logic        en_prev_q;
  logic        mode_q;
  logic        above_q;
  logic        en_rise;
  // Bus
  logic        wr_en;
  logic        rd_sel;
  logic [31:0] rd_data;
  logic        rd_err;
  logic [9:0]  int_act;
  logic [23:0] frac_act;
  logic        carry;

  function automatic logic [2:0] ref_ratio(input logic byp, input logic [2:0] val);
    if (byp) begin
      ref_ratio = 3'h1;
    end else if (val < fnsc_pkg::REF_MIN) begin
      ref_ratio = fnsc_pkg::REF_MIN;
    end else begin
      ref_ratio = val;
    end
  endfunction

  function automatic logic [7:0] pump_ua(input logic [4:0] code, input logic low);
    int full;
    full = low ? fnsc_pkg::PUMP_LOW_UA : fnsc_pkg::PUMP_FULL_UA;
    pump_ua = 8'((int'(code) * full) / fnsc_pkg::PUMP_CODE_MAX);
  endfunction

  // Pin changes count once the second and third stages agree
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      en_sync_q    <= 3'h0;
      mode_sync_q  <= 3'h0;
      above_sync_q <= 3'h0;
      en_q         <= 1'b0;
      en_prev_q    <= 1'b0;
      mode_q       <= 1'b0;
      above_q      <= 1'b0;
    end else begin
      en_sync_q    <= {en_sync_q[1:0], chip_enable_pin_i};
      mode_sync_q  <= {mode_sync_q[1:0], mode_pin_i};
      above_sync_q <= {above_sync_q[1:0], vco_above_i};
      en_prev_q    <= en_q;
      if (en_sync_q[1] == en_sync_q[2]) begin
        en_q <= en_sync_q[2];
      end
      if (mode_sync_q[1] == mode_sync_q[2]) begin
        mode_q <= mode_sync_q[2];
      end
      if (above_sync_q[1] == above_sync_q[2]) begin
        above_q <= above_sync_q[2];
      end
    end
  end

  assign en_rise = en_q && !en_prev_q;

  // APB: one wait state, write lands on the edge that samples pready
  assign wr_en  = psel_i && penable_i && pready_o && pwrite_i;
  assign rd_sel = psel_i && penable_i && !pready_o;

  always_comb begin
    rd_data = 32'h0;
    rd_err  = 1'b0;
    if (paddr_i == fnsc_pkg::ADDR_CTRL) begin
      rd_data[12:0] = {vcoi_q, ctv_q, cal_en_q, lo_div_q, vco_sel_q};
    end else if (paddr_i == fnsc_pkg::ADDR_BAND) begin
      rd_data[6:0] = band_def_q;
    end else if (paddr_i == fnsc_pkg::ADDR_B1_INT) begin
      rd_data[9:0] = int1_q;
    end else if (paddr_i == fnsc_pkg::ADDR_B1_FHI) begin
      rd_data[15:0] = frac1_q[23:8];
    end else if (paddr_i == fnsc_pkg::ADDR_B1_FLO) begin
      rd_data[7:0] = frac1_q[7:0];
    end else if (paddr_i == fnsc_pkg::ADDR_B2_INT) begin
      rd_data[9:0] = int2_q;
    end else if (paddr_i == fnsc_pkg::ADDR_B2_FHI) begin
      rd_data[15:0] = frac2_q[23:8];
    end else if (paddr_i == fnsc_pkg::ADDR_B2_FLO) begin
      rd_data[7:0] = frac2_q[7:0];
    end else if (paddr_i == fnsc_pkg::ADDR_REFDIV) begin
      rd_data[15:13] = ref_val_q;
      rd_data[0]     = ref_byp_q;
    end else if (paddr_i == fnsc_pkg::ADDR_PUMP) begin
      rd_data[9:0] = {lf_q, 1'b0, auto_bw_q, pump_low_q, pump_q};
    end else if (paddr_i == fnsc_pkg::ADDR_FILT) begin
      rd_data[5:0] = {loi_q, pol_q, filt_act_q};
    end else if (paddr_i == fnsc_pkg::ADDR_STATUS) begin
      rd_data[11:0] = {mode_q, loop_closed_o, done_q, state_q == CAL_SEARCH,
                       (result_q == fnsc_pkg::BAND_MIN) || (result_q == fnsc_pkg::BAND_MAX),
                       result_q};
    end else begin
      rd_err = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready_o  <= 1'b0;
      prdata_o  <= 32'h0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= rd_sel;
      if (rd_sel) begin
        prdata_o  <= pwrite_i ? 32'h0 : rd_data;
        pslverr_o <= rd_err;
      end else begin
        pslverr_o <= 1'b0;
      end
    end
  end

  // Configuration registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      vco_sel_q  <= fnsc_pkg::RST_VCO;
      lo_div_q   <= 1'b0;
      cal_en_q   <= fnsc_pkg::RST_CALEN;
      ctv_q      <= fnsc_pkg::RST_CTV;
      vcoi_q     <= fnsc_pkg::RST_VCOI;
      band_def_q <= fnsc_pkg::RST_BAND;
      int1_q     <= fnsc_pkg::RST_INT;
      int2_q     <= fnsc_pkg::RST_INT;
      frac1_q    <= 24'h0;
      frac2_q    <= 24'h0;
      ref_byp_q  <= 1'b0;
      ref_val_q  <= fnsc_pkg::RST_REFV;
      pump_q     <= fnsc_pkg::RST_PUMP;
      pump_low_q <= 1'b0;
      auto_bw_q  <= 1'b0;
      lf_q       <= fnsc_pkg::RST_LF;
      filt_act_q <= 1'b0;
      pol_q      <= 1'b0;
      loi_q      <= fnsc_pkg::RST_LOI;
    end else if (wr_en) begin
      if (paddr_i == fnsc_pkg::ADDR_CTRL) begin
        vco_sel_q <= pwdata_i[fnsc_pkg::CTRL_VCO_LSB +: 2];
        lo_div_q  <= pwdata_i[fnsc_pkg::CTRL_LODIV];
        cal_en_q  <= pwdata_i[fnsc_pkg::CTRL_CALEN];
        ctv_q     <= pwdata_i[fnsc_pkg::CTRL_CTV_LSB +: 5];
        vcoi_q    <= pwdata_i[fnsc_pkg::CTRL_VCOI_LSB +: 4];
      end else if (paddr_i == fnsc_pkg::ADDR_BAND) begin
        band_def_q <= pwdata_i[6:0];
      end else if (paddr_i == fnsc_pkg::ADDR_B1_INT) begin
        int1_q <= pwdata_i[9:0];
      end else if (paddr_i == fnsc_pkg::ADDR_B1_FHI) begin
        frac1_q[23:8] <= pwdata_i[15:0];
      end else if (paddr_i == fnsc_pkg::ADDR_B1_FLO) begin
        frac1_q[7:0] <= pwdata_i[7:0];
      end else if (paddr_i == fnsc_pkg::ADDR_B2_INT) begin
        int2_q <= pwdata_i[9:0];
      end else if (paddr_i == fnsc_pkg::ADDR_B2_FHI) begin
        frac2_q[23:8] <= pwdata_i[15:0];
      end else if (paddr_i == fnsc_pkg::ADDR_B2_FLO) begin
        frac2_q[7:0] <= pwdata_i[7:0];
      end else if (paddr_i == fnsc_pkg::ADDR_REFDIV) begin
        ref_byp_q <= pwdata_i[fnsc_pkg::REF_BYP];
        ref_val_q <= pwdata_i[fnsc_pkg::REF_VAL_LSB +: 3];
      end else if (paddr_i == fnsc_pkg::ADDR_PUMP) begin
        pump_q     <= pwdata_i[4:0];
        pump_low_q <= pwdata_i[fnsc_pkg::PUMP_LOW];
        auto_bw_q  <= pwdata_i[fnsc_pkg::PUMP_AUTO];
        lf_q       <= pwdata_i[fnsc_pkg::PUMP_LF_LSB +: 2];
      end else if (paddr_i == fnsc_pkg::ADDR_FILT) begin
        filt_act_q <= pwdata_i[fnsc_pkg::FILT_ACT];
        pol_q      <= pwdata_i[fnsc_pkg::FILT_POL];
        loi_q      <= pwdata_i[fnsc_pkg::FILT_LOI_LSB +: 4];
      end
    end
  end

  // Done flag, write one to clear; a new result wins over the clear
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      done_q <= 1'b0;
    end else if (cal_done_ev) begin
      done_q <= 1'b1;
    end else if (wr_en && paddr_i == fnsc_pkg::ADDR_STATUS && pwdata_i[fnsc_pkg::STAT_DONE]) begin
      done_q <= 1'b0;
    end
  end

  // Band search: start at no added capacitance, add one step per dwell
  assign cal_done_ev = (state_q == CAL_SEARCH) && pd_tick_i &&
                       (tick_q == 8'(STEP_TICKS - 1)) &&
                       (!above_q || band_q == fnsc_pkg::BAND_MAX);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q  <= CAL_IDLE;
      band_q   <= fnsc_pkg::RST_BAND;
      result_q <= fnsc_pkg::BAND_MIN;
      tick_q   <= 8'h0;
    end else if (!en_q) begin
      state_q <= CAL_IDLE;
      tick_q  <= 8'h0;
    end else begin
      case (state_q)
        CAL_IDLE: begin
          if (en_rise && cal_en_q) begin
            state_q <= CAL_SEARCH;
            band_q  <= fnsc_pkg::BAND_MIN;
            tick_q  <= 8'h0;
          end else if (en_rise) begin
            state_q <= CAL_LOCK;
            band_q  <= band_def_q;
          end
        end
        CAL_SEARCH: begin
          if (pd_tick_i) begin
            if (tick_q != 8'(STEP_TICKS - 1)) begin
              tick_q <= tick_q + 8'h1;
            end else begin
              tick_q <= 8'h0;
              if (cal_done_ev) begin
                result_q <= band_q;
                state_q  <= CAL_LOCK;
              end else begin
                band_q <= band_q + 7'h1;
              end
            end
          end
        end
        CAL_LOCK: begin
          state_q <= CAL_LOCK;
        end
        default: begin
          state_q <= CAL_IDLE;
        end
      endcase
    end
  end

  // Bank choice by mode pin
  assign int_act  = mode_q ? int2_q : int1_q;
  assign frac_act = mode_q ? frac2_q : frac1_q;

  fnsc_frac_seq #(
    .W (fnsc_pkg::FRAC_W)
  ) u_frac_seq (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .step_i  (fb_tick_i),
    .frac_i  (frac_act),
    .carry_o (carry)
  );

  // Output registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      vco_select_o          <= fnsc_pkg::RST_VCO;
      lo_div4_o             <= 1'b0;
      vco_band_o            <= fnsc_pkg::RST_BAND;
      coarse_tune_voltage_o <= fnsc_pkg::RST_CTV;
      vco_core_current_o    <= fnsc_pkg::RST_VCOI;
      lo_buffer_current_o   <= fnsc_pkg::RST_LOI;
      loop_closed_o         <= 1'b0;
      ref_div_ratio_o       <= fnsc_pkg::RST_REFV;
      fb_div_ratio_o        <= {1'b0, fnsc_pkg::RST_INT};
      pump_code_o           <= fnsc_pkg::RST_PUMP;
      pump_ua_o             <= 8'(fnsc_pkg::PUMP_FULL_UA);
      loop_factor_select_o  <= fnsc_pkg::RST_LF;
      filter_amp_en_o       <= 1'b0;
      filter_pin_hiz_o      <= 1'b1;
      detector_polarity_o   <= 1'b0;
    end else begin
      vco_select_o          <= vco_sel_q;
      lo_div4_o             <= lo_div_q;
      vco_band_o            <= band_q;
      coarse_tune_voltage_o <= ctv_q;
      vco_core_current_o    <= vcoi_q;
      lo_buffer_current_o   <= loi_q;
      loop_closed_o         <= en_q && (state_q == CAL_LOCK);
      ref_div_ratio_o       <= ref_ratio(ref_byp_q, ref_val_q);
      fb_div_ratio_o        <= {1'b0, int_act} + {10'h0, carry};
      pump_code_o           <= auto_bw_q ? vco_gain_code_i : pump_q;
      pump_ua_o             <= pump_ua(auto_bw_q ? vco_gain_code_i : pump_q,
                                       pump_low_q);
      loop_factor_select_o  <= lf_q;
      filter_amp_en_o       <= filt_act_q;
      filter_pin_hiz_o      <= !filt_act_q;
      detector_polarity_o   <= pol_q;
    end
  end

  property p_start_search;
    @(posedge clk_i) disable iff (!rst_n_i)
      (state_q == CAL_IDLE && en_rise && cal_en_q) |=> (state_q == CAL_SEARCH && band_q == 7'h00);
  endproperty
  a_start_search: assert property (p_start_search) else $error("no search on enable rise");

  property p_default_band;
    @(posedge clk_i) disable iff (!rst_n_i)
      (state_q == CAL_IDLE && en_rise && !cal_en_q) |=> (state_q == CAL_LOCK && band_q == $past(band_def_q));
  endproperty
  a_default_band: assert property (p_default_band) else $error("default band not applied");

  property p_step_one;
    @(posedge clk_i) disable iff (!rst_n_i)
      (state_q == CAL_SEARCH && $past(state_q) == CAL_SEARCH && en_q) |->
        (band_q == $past(band_q) || band_q == $past(band_q) + 7'h1);
  endproperty
  a_step_one: assert property (p_step_one) else $error("band moved by more than one");

  property p_result;
    @(posedge clk_i) disable iff (!rst_n_i)
      cal_done_ev && en_q |=> (result_q == $past(band_q) && state_q == CAL_LOCK);
  endproperty
  a_result: assert property (p_result) else $error("result not stored");

  property p_dwell;
    @(posedge clk_i) disable iff (!rst_n_i)
      (state_q == CAL_SEARCH && tick_q != 8'(STEP_TICKS - 1) && !pd_tick_i && en_q) |=> $stable(band_q);
  endproperty
  a_dwell: assert property (p_dwell) else $error("band stepped without a full dwell");

  property p_ref_ratio;
    @(posedge clk_i) disable iff (!rst_n_i)
      ##1 (ref_div_ratio_o == ($past(ref_byp_q) ? 3'h1 :
           ($past(ref_val_q) < 3'h2 ? 3'h2 : $past(ref_val_q))));
  endproperty
  a_ref_ratio: assert property (p_ref_ratio) else $error("reference ratio wrong");

  property p_bank;
    @(posedge clk_i) disable iff (!rst_n_i)
      ##1 (fb_div_ratio_o == {1'b0, ($past(mode_q) ? $past(int2_q) : $past(int1_q))} +
           {10'h0, $past(carry)});
  endproperty
  a_bank: assert property (p_bank) else $error("feedback ratio from wrong bank");

  property p_pump_full;
    @(posedge clk_i) disable iff (!rst_n_i)
      (pump_code_o == 5'h1F && !pump_low_q && !auto_bw_q && $stable(pump_low_q)) |->
        pump_ua_o == 8'h78 || $changed(pump_code_o);
  endproperty
  a_pump_full: assert property (p_pump_full) else $error("full pump current not 120 uA");

  property p_filter;
    @(posedge clk_i) disable iff (!rst_n_i)
      $rose(filt_act_q) |=> (filter_amp_en_o && !filter_pin_hiz_o);
  endproperty
  a_filter: assert property (p_filter) else $error("filter amplifier not enabled");

  property p_loop_closed;
    @(posedge clk_i) disable iff (!rst_n_i)
      loop_closed_o |-> $past(state_q) == CAL_LOCK;
  endproperty
  a_loop_closed: assert property (p_loop_closed) else $error("loop closed before lock");

  c_cal_ok: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    cal_done_ev && band_q != 7'h00 && band_q != 7'h7F);
  c_cal_fail: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    cal_done_ev && band_q == 7'h7F);
  c_bypass: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    ref_byp_q && loop_closed_o);
  c_bank2: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    mode_q && carry);
endmodule

// *** test/fnsc_vco_model.sv ***
// Behavioural oscillator and phase detector clock of the far side
`timescale 1ns/1ns
module fnsc_vco_model (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // Band in use and band that meets the target
  input  wire logic [6:0] band_i,
  input  wire logic [6:0] target_i,
  // Tick and comparator
  output logic            pd_tick_o,
  output logic            above_o
);
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pd_tick_o <= 1'b0;
    end else begin
      pd_tick_o <= !pd_tick_o;
    end
  end
  // More capacitance lowers the frequency
  assign above_o = band_i < target_i;
endmodule

// *** test/fnsc_tb.sv ***
// Self-checking testbench of the synthesizer control block
`timescale 1ns/1ns
module testbench;
  logic        clk_i = 0, rst_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic        en_q = 0, mode_q = 0, tick, above, pready_o, pslverr_o, closed;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0, prdata_o, r;
  logic [6:0]  tgt = 7'h00, band;
  logic [2:0]  refr;
  logic [10:0] fbr;
  logic [7:0]  ua;
  logic        amp, hiz, e;
  logic [1:0]  vsel, lf;
  logic [4:0]  ctv, pc, gain = 5'h00;
  logic [3:0]  vcoi, loi;
  logic        div4, pol, fbt = 0;
  logic [10:0] s;
  int          err_count = 0, checks_done = 0;
  fnsc_vco_model u_vco (.clk_i(clk_i), .rst_n_i(rst_n_i), .band_i(band), .target_i(tgt),
    .pd_tick_o(tick), .above_o(above));
  fnsc_synth_ctrl #(.STEP_TICKS(4)) DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .chip_enable_pin_i(en_q), .mode_pin_i(mode_q), .vco_above_i(above), .pd_tick_i(tick),
    .fb_tick_i(fbt), .vco_gain_code_i(gain), .vco_select_o(vsel), .lo_div4_o(div4),
    .vco_band_o(band), .coarse_tune_voltage_o(ctv), .vco_core_current_o(vcoi),
    .lo_buffer_current_o(loi), .loop_closed_o(closed), .ref_div_ratio_o(refr),
    .fb_div_ratio_o(fbr), .pump_code_o(pc), .pump_ua_o(ua), .loop_factor_select_o(lf),
    .filter_amp_en_o(amp), .filter_pin_hiz_o(hiz), .detector_polarity_o(pol));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    if (n >= 50) begin
      err_count++;
      final_report();
    end
    // Bus idle while registered outputs settle
    repeat (2) @(posedge clk_i);
  endtask
  task automatic wait_lock;
    int n;
    n = 0;
    en_q <= 1'b1;
    while (closed !== 1'b1 && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 3000) begin
      err_count++;
      final_report();
    end
  endtask
  task automatic t_reset;
    apb(1'b0, 12'h000, 32'h0);
    chk(r, 32'h108);
    apb(1'b0, 12'h024, 32'h0);
    chk(r, 32'h11F);
    chk(ua, 8'h78);
    apb(1'b0, 12'h030, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
    $display("reset test done");
  endtask
  task automatic t_cal(input logic [6:0] t, input logic f);
    tgt = t;
    wait_lock();
    chk(band, t);
    apb(1'b0, 12'h02C, 32'h0);
    chk(r[7:0], {f, t});
    en_q <= 1'b0;
    repeat (8) @(posedge clk_i);
    $display("calibration test done");
  endtask
  task automatic t_default;
    apb(1'b1, 12'h000, 32'h100);
    apb(1'b1, 12'h004, 32'h55);
    tgt = 7'h10;
    wait_lock();
    chk(band, 7'h55);
    en_q <= 1'b0;
    $display("default band test done");
  endtask
  task automatic t_paths;
    apb(1'b1, 12'h000, 32'hAC6);
    chk({vsel, div4, ctv, vcoi}, 32'hAC5);
    apb(1'b1, 12'h020, 32'hE000);
    chk(refr, 3'h7);
    apb(1'b1, 12'h020, 32'hE001);
    chk(refr, 3'h1);
    apb(1'b1, 12'h014, 32'h5C);
    mode_q <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk(fbr, 11'h05C);
    mode_q <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk(fbr, 11'h040);
    apb(1'b1, 12'h00C, 32'h8000);
    fbt <= 1'b1;
    repeat (4) @(posedge clk_i);
    s = fbr;
    @(posedge clk_i);
    chk(s + fbr, 32'h81);
    fbt <= 1'b0;
    apb(1'b1, 12'h024, 32'h13F);
    apb(1'b1, 12'h028, 32'h33);
    @(posedge clk_i);
    chk(ua, 8'h1E);
    chk({amp, hiz}, 2'b10);
    chk({pol, loi}, 32'h1C);
    chk({pc, lf}, 32'h7D);
    gain <= 5'h10;
    apb(1'b1, 12'h024, 32'h140);
    chk({pc, ua}, 32'h103D);
    $display("divider and pump test done");
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    t_reset();
    t_cal(7'h25, 1'b0);
    t_cal(7'h00, 1'b1);
    t_cal(7'h7F, 1'b1);
    t_default();
    t_paths();
    final_report();
  end
endmodule
